/* File: rtl/rrc_defs.svh */
// Offsets, reset values and divider counts of the rate-trim block
`ifndef RRC_DEFS_SVH
`define RRC_DEFS_SVH
`define RRC_TRIM_OFFSET 12'h000
`define RRC_STATUS_OFFSET 12'h004
`define RRC_TRIM_RESET 8'h00
`define RRC_TICKS_PER_SEC 16'h8000
`define RRC_HALF_SEC 16'h4000
`define RRC_SHORT_INTERVAL 6'h14
`define RRC_LONG_INTERVAL 6'h3C
`define RRC_NEG_THRESHOLD 7'h40
`define RRC_STATUS_SEC_LSB 0
`define RRC_STATUS_ACTIVE_BIT 8
`define RRC_STATUS_LEN_LSB 16
`endif

/* File: rtl/rrc_pkg.sv */
// Types and trim decoding shared by the rate-trim block
package rrc_pkg;
`include "rrc_defs.svh"

  typedef struct packed {
    logic [6:0] rev_trim;
    logic long_mode;
  } rrc_trim_t;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } rrc_apb_req_t;

  // Field holds the value with its bits in reverse order
  function automatic logic [6:0] rrc_unreverse(input logic [6:0] r);
    logic [6:0] v;
    v = 7'h00;
    for (int i = 0; i < 7; i++) begin
      v[i] = r[6 - i];
    end
    return v;
  endfunction

  // Length of the corrected second in oscillator ticks, two ticks per step
  function automatic logic [15:0] rrc_period(input rrc_trim_t t);
    logic [6:0] v;
    logic [6:0] neg;
    v = rrc_unreverse(t.rev_trim);
    neg = 7'(7'h00 - v);
    if (v < `RRC_NEG_THRESHOLD) begin
      return 16'(`RRC_TICKS_PER_SEC - {8'h00, v, 1'b0});
    end else begin
      return 16'(`RRC_TICKS_PER_SEC + {8'h00, neg, 1'b0});
    end
  endfunction
endpackage

/* File: rtl/rrc_divider.sv */
// Timekeeping divider stage counting oscillator ticks into seconds
`timescale 1ns/10ps
module rrc_divider
  import rrc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic [15:0] sec_len,
  output logic [15:0] phase,
  output logic sec_pulse
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic pulse_reg;
  logic pulse_next;
  wire last_tick = (cnt_reg >= 16'(sec_len - 16'h0001));

  // Wrap on >= so a shorter length written mid-second cannot run away
  assign cnt_next = !tick ? cnt_reg : (last_tick ? 16'h0000 : 16'(cnt_reg + 16'h0001));
  assign pulse_next = tick & last_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 16'h0000;
      pulse_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      pulse_reg <= pulse_next;
    end
  end

  assign phase = cnt_reg;
  assign sec_pulse = pulse_reg;
endmodule

/* File: rtl/rrc_top.sv */
// Rate-trim block: APB trim register, divider chain with correction, 1 Hz pin
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "rrc_defs.svh"
module rrc_top
  import rrc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xtal_pin,
  output logic clk32k_out,
  output logic first_interrupt_pin_n
);
  rrc_apb_req_t req;
  rrc_trim_t trim_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic out32_reg;
  logic first_interrupt_pin_n_reg;
  logic [5:0] sec_reg;
  logic [5:0] sec_next;
  logic [15:0] phase;
  logic sec_pulse;

  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

  // APB decode
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_reg;
  wire hit_trim = (req.addr == `RRC_TRIM_OFFSET);
  wire hit_status = (req.addr == `RRC_STATUS_OFFSET);
  wire hit_any = hit_trim | hit_status;
  wire trim_wr = access & req.write & hit_trim;

  // Oscillator tick from the pin, seen only after two flops
  wire tick = sync2_reg & ~sync3_reg;

  // Interval length and corrected second
  wire [5:0] interval = trim_reg.long_mode ? `RRC_LONG_INTERVAL : `RRC_SHORT_INTERVAL;
  wire last_sec = (sec_reg >= 6'(interval - 6'h01));
  wire [15:0] trimmed_len = rrc_period(trim_reg);
  wire [15:0] sec_len = last_sec ? trimmed_len : `RRC_TICKS_PER_SEC;
  wire corr_active = last_sec & (trimmed_len != `RRC_TICKS_PER_SEC);

  assign sec_next = !sec_pulse ? sec_reg : (last_sec ? 6'h00 : 6'(sec_reg + 6'h01));

  wire [31:0] status_word = ({26'h0000000, sec_reg} << `RRC_STATUS_SEC_LSB)
    | ({31'h00000000, corr_active} << `RRC_STATUS_ACTIVE_BIT)
    | ({16'h0000, sec_len} << `RRC_STATUS_LEN_LSB);
  wire [31:0] read_word = hit_trim ? {24'h000000, trim_reg} :
    (hit_status ? status_word : 32'h00000000);

  // Low half of each second on the pin; the corrected second lengthens or shortens only its high half
  wire first_interrupt_pin_next = (phase >= `RRC_HALF_SEC);

  rrc_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .sec_len(sec_len),
    .phase(phase),
    .sec_pulse(sec_pulse)
  );

  // Answer one cycle after setup: pready is raised for the access phase only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~hit_any;
      prdata_reg <= (setup & ~req.write) ? read_word : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_reg <= `RRC_TRIM_RESET;
    end else if (trim_wr) begin
      trim_reg <= req.wdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      out32_reg <= 1'b0;
    end else begin
      sync1_reg <= xtal_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      out32_reg <= sync2_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_reg <= 6'h00;
      first_interrupt_pin_n_reg <= 1'b0;
    end else begin
      sec_reg <= sec_next;
      first_interrupt_pin_n_reg <= first_interrupt_pin_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign clk32k_out = out32_reg;
  assign first_interrupt_pin_n = first_interrupt_pin_n_reg;
endmodule

/* File: sim/rrc_top_sva.sv */
// Checker on the rate-trim block ports
`timescale 1ns/10ps
module rrc_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic xtal_pin,
  input wire logic clk32k_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = pready && !pslverr && !pwrite;
  wire tr = rd && paddr == 12'h000;
  wire st = rd && paddr == 12'h004;
  AST_SETUP: assert property (psel && !penable |=> pready) else $error("no ready");
  AST_ONE: assert property (pready |=> !pready) else $error("ready held");
  AST_ERR: assert property (pslverr |-> pready) else $error("stray slverr");
  AST_IDLE: assert property (!pready |-> prdata == 0) else $error("idle data");
  AST_TRIM: assert property (tr |-> prdata[31:8] == 0) else $error("trim bits");
  AST_K32: assert property ($past(presetn, 3) |-> clk32k_out == $past(xtal_pin, 3))
    else $error("32k copy");
  AST_LEN: assert property (st |-> prdata[31:16] inside {[16'h7F82:16'h8080]})
    else $error("length");
  AST_LAST: assert property (st && prdata[8] |-> prdata[5:0] inside {6'h13, 6'h3B})
    else $error("active");
endmodule
bind rrc_top rrc_top_sva rrc_top_sva_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .xtal_pin, .clk32k_out);

/* File: sim/rrc_top_test.sv */
// Bench for the rate-trim block
`timescale 1ns/10ps
module rrc_top_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, xtal_pin = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, clk32k_out, first_interrupt_pin_n;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  always #50 pclk = !pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  // Fast oscillator keeps the run short
  always @(posedge pclk) xtal_pin <= presetn && !xtal_pin;
  rrc_top rrc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .xtal_pin, .clk32k_out, .first_interrupt_pin_n);
  task automatic summarize;
    $display("Checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, g);
    tests_run++;
    if (g !== x) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  // Request held until the rising edge that samples pready high; data taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      error_cnt++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic t_regs;
    apb(0, 0, 0);
    chk("trim reset", 0, q);
    apb(0, 4, 0);
    chk("status", 32'h8000_0000, q);
    apb(1, 0, 32'hABCDEF03);
    apb(0, 0, 0);
    chk("trim long mode", 32'h03, q);
    apb(0, 4, 0);
    chk("status long mode", 32'h8000_0000, q);
    apb(1, 0, 32'hABCDEF56);
    apb(0, 0, 0);
    chk("trim slow down", 32'h56, q);
    apb(1, 0, 32'hABCDEFD8);
    apb(0, 0, 0);
    chk("trim speed up", 32'hD8, q);
  endtask
  task automatic t_unmapped;
    apb(1, 12'h008, 0);
    chk("unmapped", 1, {31'h0, e});
    apb(0, 0, 0);
    chk("trim kept", 32'hD8, q);
  endtask
  task automatic t_pulse;
    repeat (40000) if (first_interrupt_pin_n !== 1'b1) @(negedge pclk);
    chk("half second", 1, {31'h0, cyc >= 32770 && cyc <= 32792});
    // A full untrimmed second is 32768 ticks, two pclk cycles per tick here
    repeat (40000) if (first_interrupt_pin_n !== 1'b0) @(negedge pclk);
    chk("full second", 1, {31'h0, cyc >= 65540 && cyc <= 65560});
    apb(0, 4, 0);
    chk("status second one", 32'h8000_0001, q);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    chk("pin in reset", 0, {31'h0, first_interrupt_pin_n});
    presetn <= 1;
    t_regs();
    t_unmapped();
    t_pulse();
    summarize();
  end
endmodule
